// file: hdl/dpc_frame_rx.sv
// Serial frame receiver running on the host's serial clock
`timescale 1ns/1ps
module dpc_frame_rx
  import dpc_pkg::*;
(
  // Link pins
  input  wire logic                  link_clk_in,
  input  wire logic                  sync_n_in,
  input  wire logic                  din_in,
  // Frame to the system side
  output logic                       frame_done_out,
  output logic [FRAME_BITS-1:0]      frame_word_out
);

  // ==========================================================
  // Bit counter
  // Cleared by frame select high, so no link edge is needed outside a frame
  logic [CNT_W-1:0] cnt_reg;
  logic             done_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  wire              last_bit = (cnt_reg == FRAME_LAST - 5'h01);
  wire              shifting = (cnt_reg != FRAME_LAST);

  always_ff @(posedge link_clk_in or posedge sync_n_in) begin
    if (sync_n_in) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else if (shifting) begin
      cnt_reg  <= cnt_reg + 5'h01;
      done_reg <= last_bit;
    end
  end

  // ==========================================================
  // Shift register, MSB first; frozen after the sixteenth bit
  // Holds its word while select is high so the system side can read it
  always_ff @(posedge link_clk_in) begin
    if (!sync_n_in && shifting) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], din_in};
    end
  end

  assign frame_done_out = done_reg;
  assign frame_word_out = shift_reg;

endmodule // dpc_frame_rx

// file: hdl/dpc_pkg.sv
// Constants, opcodes and carrier types of the DAC power-down control block
package dpc_pkg;

  // ==========================================================
  // Channels and frame layout
  localparam int          NUM_CH       = 8;
  localparam int          CODE_W       = 12;
  localparam int          FRAME_BITS   = 16;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  FRAME_LAST   = 5'h10;
  localparam int          OP_MSB       = 15;
  localparam int          OP_LSB       = 12;
  localparam int          ADDR_MSB     = 14;
  localparam int          ADDR_LSB     = 12;
  localparam logic [3:0]  OP_PD_HIZ    = 4'hd;
  localparam logic [3:0]  OP_PD_100K   = 4'he;
  localparam logic [3:0]  OP_PD_2K5    = 4'hf;

  // ==========================================================
  // Reset values
  localparam logic [11:0] CODE_RESET   = 12'h000;
  localparam logic [15:0] WORD_RESET   = 16'h0000;

  // ==========================================================
  // Recovery timing at 200 MHz
  localparam int          CLK_PERIOD_PS = 5000;
  localparam int          RECOVER_MAX_NS = 20000;
  localparam int          RECOVER_CYC  = (RECOVER_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int          CODE_SPAN    = 4096;
  localparam logic [12:0] RAMP_STEP    = 13'((CODE_SPAN + RECOVER_CYC - 1) / RECOVER_CYC);

  // ==========================================================
  // Register map, byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_PWR      = 8'h08;
  localparam logic [7:0]  OFS_LAST     = 8'h0c;
  localparam logic [7:0]  OFS_DATA0    = 8'h20;
  localparam int          CTRL_SOFT_POR = 0;
  localparam int          STAT_BIAS    = 0;
  localparam int          STAT_PD_LSB  = 8;
  localparam int          STAT_CNT_LSB = 16;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PS_ACTIVE,
    PS_HIZ,
    PS_100K,
    PS_2K5
  } dpc_pwr_t;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic              pd_switch;
    dpc_pwr_t          term;
  } dpc_chan_t;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } dpc_avs_req_t;

endpackage

// file: hdl/dpc_power_ctrl.sv
// Power-on reset and per-channel power-down control of an eight-channel DAC
//
// Contract
// - Reset clears every channel data register to zero.
// - All channel outputs sit at code zero through reset and until a write changes them.
// - Opcodes 1101, 1110 and 1111 power down with high-Z, 100k and 2.5k terminations, bits 11 to 8 ignored.
// - In a power-down frame bit i selects channel i and every selected channel goes down.
// - A powered-down channel has its core and buffer switch asserted off.
// - The shared bias stays on while any channel is active and goes off only with all eight down.
// - Power-down never alters a channel data register.
// - Frames are accepted whatever the power state of the channels.
// - A write to a powered-down channel is stored, as to an active one, and wakes the channel.
// - A waking channel ramps its code from zero up to its data register.
// - A frame with bit 15 clear writes its 12-bit value to the channel in bits 14 to 12.
`timescale 1ns/1ps
module dpc_power_ctrl
  import dpc_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  // Serial link
  input  wire logic                  link_clk_in,
  input  wire logic                  sync_n_in,
  input  wire logic                  din_in,
  // Avalon-MM slave
  input  wire dpc_pkg::dpc_avs_req_t avs_req_in,
  output logic [31:0]                avs_readdata_out,
  output logic                       avs_waitrequest_out,
  // Analog control
  output dpc_pkg::dpc_chan_t [7:0]   chan_out,
  output logic                       bias_en_out
);
  import dpc_pkg::*;

  // ==========================================================
  // Frame crossing
  logic                  link_done;
  logic [FRAME_BITS-1:0] link_word;
  logic                  done_meta_reg;
  logic                  done_sync_reg;
  logic                  done_prev_reg;
  logic                  frame_vld_reg;
  logic [FRAME_BITS-1:0] word_reg;
  logic [15:0]           frame_cnt_reg;
  logic                  soft_por_reg;

  dpc_frame_rx u_rx (
    .link_clk_in    (link_clk_in),
    .sync_n_in      (sync_n_in),
    .din_in         (din_in),
    .frame_done_out (link_done),
    .frame_word_out (link_word)
  );

  // Word is stable while done stands high, so a level sync suffices
  wire frame_stb = done_sync_reg & ~done_prev_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      done_meta_reg <= 1'b0;
      done_sync_reg <= 1'b0;
      done_prev_reg <= 1'b0;
      frame_vld_reg <= 1'b0;
      word_reg      <= WORD_RESET;
      frame_cnt_reg <= '0;
    end else begin
      done_meta_reg <= link_done;
      done_sync_reg <= done_meta_reg;
      done_prev_reg <= done_sync_reg;
      frame_vld_reg <= frame_stb;
      if (frame_stb) begin
        word_reg      <= link_word;
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Frame decode
  wire [3:0] opcode   = word_reg[OP_MSB:OP_LSB];
  wire [2:0] wr_addr  = word_reg[ADDR_MSB:ADDR_LSB];
  wire       is_write = frame_vld_reg & ~word_reg[OP_MSB];
  wire       is_hiz   = (opcode == OP_PD_HIZ);
  wire       is_100k  = (opcode == OP_PD_100K);
  wire       is_2k5   = (opcode == OP_PD_2K5);
  wire       is_pd    = frame_vld_reg & (is_hiz | is_100k | is_2k5);
  wire dpc_pwr_t pd_kind = is_hiz  ? PS_HIZ  :
                           is_100k ? PS_100K : PS_2K5;
  wire       init     = rst_in | soft_por_reg;

  // ==========================================================
  // Per-channel state
  logic [CODE_W-1:0] data_reg [NUM_CH];
  logic [CODE_W-1:0] code_reg [NUM_CH];
  dpc_pwr_t          pwr_reg  [NUM_CH];
  logic              ramp_reg [NUM_CH];
  logic [NUM_CH-1:0] active;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      wire              wr_hit = is_write & (wr_addr == 3'(gi));
      wire              pd_hit = is_pd & word_reg[gi];
      wire [12:0]       sum    = {1'b0, code_reg[gi]} + RAMP_STEP;
      wire              reach  = (sum >= {1'b0, data_reg[gi]});
      logic [CODE_W-1:0] data_next;
      logic [CODE_W-1:0] code_next;
      dpc_pwr_t          pwr_next;
      logic              ramp_next;

      // Power-down frames never touch data; writes store even when down
      assign data_next = init   ? CODE_RESET   :
                         wr_hit ? word_reg[CODE_W-1:0] :
                                  data_reg[gi];
      // Data write wakes the channel
      assign pwr_next  = init   ? PS_ACTIVE    :
                         pd_hit ? pd_kind      :
                         wr_hit ? PS_ACTIVE    : pwr_reg[gi];
      assign ramp_next = init ? 1'b0 :
                         (pwr_reg[gi] != PS_ACTIVE) ? 1'b1 :
                         (ramp_reg[gi] & ~reach);
      // Step sized to finish a full-scale ramp inside the recovery time
      assign code_next = init ? CODE_RESET :
                         (pwr_reg[gi] != PS_ACTIVE) ? CODE_RESET :
                         (ramp_reg[gi] & ~reach) ? sum[CODE_W-1:0] :
                         data_reg[gi];

      always_ff @(posedge ref_clk_in) begin
        data_reg[gi] <= data_next;
        pwr_reg[gi]  <= pwr_next;
        ramp_reg[gi] <= ramp_next;
        code_reg[gi] <= code_next;
      end

      assign active[gi]            = (pwr_reg[gi] == PS_ACTIVE);
      assign chan_out[gi].code      = code_reg[gi];
      assign chan_out[gi].pd_switch = ~active[gi];
      assign chan_out[gi].term      = pwr_reg[gi];
    end
  endgenerate

  // ==========================================================
  // Shared bias
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bias_en_out <= 1'b1;
    end else begin
      bias_en_out <= |active;
    end
  end

  // ==========================================================
  // Avalon-MM slave, one wait state on every access
  logic        ack_reg;
  logic [31:0] rdata_reg;
  wire         req      = avs_req_in.read | avs_req_in.write;
  wire  [7:0]  addr     = avs_req_in.address;
  wire         hit_ctrl = (addr == OFS_CTRL);
  wire         hit_stat = (addr == OFS_STATUS);
  wire         hit_pwr  = (addr == OFS_PWR);
  wire         hit_last = (addr == OFS_LAST);
  wire         hit_data = (addr[7:5] == OFS_DATA0[7:5]) & (addr[1:0] == 2'h0);
  wire  [2:0]  data_idx = addr[4:2];
  wire  [15:0] pwr_flat = {pwr_reg[7], pwr_reg[6], pwr_reg[5], pwr_reg[4],
                           pwr_reg[3], pwr_reg[2], pwr_reg[1], pwr_reg[0]};
  wire  [31:0] stat_word = {frame_cnt_reg, ~active, 7'h00, bias_en_out};
  wire  [31:0] rd_mux   = hit_stat ? stat_word :
                          hit_pwr  ? {16'h0000, pwr_flat} :
                          hit_last ? {16'h0000, word_reg} :
                          hit_data ? {20'h00000, data_reg[data_idx]} : 32'h00000000;
  wire         take     = req & ~ack_reg;
  wire         por_wr   = take & avs_req_in.write & hit_ctrl &
                          avs_req_in.byteenable[0] &
                          avs_req_in.writedata[CTRL_SOFT_POR];

  assign avs_waitrequest_out = req & ~ack_reg;
  assign avs_readdata_out    = rdata_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ack_reg      <= 1'b0;
      rdata_reg    <= 32'h00000000;
      soft_por_reg <= 1'b0;
    end else begin
      ack_reg      <= take;
      soft_por_reg <= por_wr;
      if (take && avs_req_in.read) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Checks
  a_por_data_zero: assert property (@(posedge ref_clk_in)
    rst_in |=> (data_reg[0] == CODE_RESET) && (data_reg[7] == CODE_RESET))
    else $error("data register not cleared by reset");

  a_por_code_zero: assert property (@(posedge ref_clk_in)
    rst_in ##1 !is_write [*2] |=> (chan_out[3].code == CODE_RESET))
    else $error("output code not zero after reset");

  a_pd_decode_kind: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (is_pd && is_100k && word_reg[3] && !soft_por_reg) |=> (pwr_reg[3] == PS_100K))
    else $error("power-down opcode decoded to wrong termination");

  a_pd_unselected: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (is_pd && !word_reg[5] && !soft_por_reg) |=> $stable(pwr_reg[5]))
    else $error("unselected channel changed power state");

  a_core_switch: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (is_pd && word_reg[1] && !soft_por_reg) |=> chan_out[1].pd_switch ##1 (chan_out[1].code == CODE_RESET))
    else $error("powered-down channel core not switched off");

  a_bias_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ##1 (bias_en_out == $past(|active)))
    else $error("bias enable does not follow channel activity");

  a_data_kept: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (is_pd && !soft_por_reg) |=> $stable(data_reg[4]))
    else $error("power-down frame altered channel data");

  a_frame_accept: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (done_sync_reg && !done_prev_reg) |=> frame_vld_reg ##1 !frame_vld_reg)
    else $error("completed frame not accepted");

  a_write_store: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (is_write && wr_addr == 3'h6 && !soft_por_reg) |=> (data_reg[6] == $past(word_reg[11:0])))
    else $error("channel write not stored");

  a_ramp_rise: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (active[1] && ramp_reg[1] && !init && $stable(data_reg[1])) |=>
      (chan_out[1].code > $past(chan_out[1].code)) || (chan_out[1].code == data_reg[1]))
    else $error("recovery ramp not rising towards data");

  a_wake_state: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!frame_vld_reg && !soft_por_reg) |=> $stable(pwr_reg[7]))
    else $error("power state changed outside a frame");

  a_bus_answer: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (req && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("bus access not answered in one wait state");

  c_pd_frame:  cover property (@(posedge ref_clk_in) disable iff (rst_in) is_pd && is_2k5);
  c_all_down:  cover property (@(posedge ref_clk_in) disable iff (rst_in) !bias_en_out);
  c_recovery:  cover property (@(posedge ref_clk_in) disable iff (rst_in)
    !active[1] ##1 active[1] && ramp_reg[1]);
  c_bus_read:  cover property (@(posedge ref_clk_in) disable iff (rst_in)
    avs_req_in.read && !avs_waitrequest_out && hit_data);

endmodule // dpc_power_ctrl

// file: verif/dpc_host_model.sv
// Host-side serial frame driver for the DAC power-down control block
`timescale 1ns/1ps
module dpc_host_model (
  // Serial link
  output logic link_clk_out,
  output logic sync_n_out,
  output logic din_out
);
  // ======================================
  // Idle levels
  initial begin
    link_clk_out = 1'b0;
    din_out      = 1'b0;
    // Receiver counter has no reset but a rising select edge, so give it one
    sync_n_out   = 1'b0;
    #1;
    sync_n_out   = 1'b1;
  end

  // ======================================
  // Frame driver
  // Clock only runs inside a frame, 12 ns period, data set up on the low phase
  task automatic send_frame(input logic [15:0] word);
    #3.3;
    sync_n_out = 1'b0;
    for (int b = 15; b >= 0; b--) begin
      din_out = word[b];
      #6;
      link_clk_out = 1'b1;
      #6;
      link_clk_out = 1'b0;
    end
    #2;
    sync_n_out = 1'b1;
    din_out    = 1'b0;
    // Select stays high well past two link periods before the next frame
    #48;
  endtask
endmodule // dpc_host_model

// file: verif/tb.sv
// Self-checking testbench of the DAC power-down control block
`timescale 1ns/1ps
module tb;
  import dpc_pkg::*;
  // ======================================
  // Signals
  logic            ref_clk_in      = 1'b0;
  logic            rst_in          = 1'b1;
  logic            link_clk;
  logic            sync_n;
  logic            din;
  dpc_avs_req_t    avs_req         = '0;
  logic [31:0]     rdata_w;
  logic            wait_w;
  dpc_chan_t [7:0] chan_w;
  logic            bias_w;
  int              error_cnt       = 0;
  int              samples_checked = 0;
  logic [11:0]     code_q [8];

  always #2.5 ref_clk_in = ~ref_clk_in;

  dpc_host_model i_host (.link_clk_out(link_clk), .sync_n_out(sync_n), .din_out(din));
  dpc_power_ctrl i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
    .sync_n_in(sync_n), .din_in(din), .avs_req_in(avs_req), .avs_readdata_out(rdata_w),
    .avs_waitrequest_out(wait_w), .chan_out(chan_w), .bias_en_out(bias_w));

  // ======================================
  // Reporting
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  function automatic logic [31:0] ce(input logic [11:0] c, input logic p, input dpc_pwr_t t);
    return {17'h0, c, p, t};
  endfunction

  // ======================================
  // Bus and link helpers
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    avs_req.address    <= a;
    avs_req.read       <= ~wr;
    avs_req.write      <= wr;
    avs_req.writedata  <= wd;
    avs_req.byteenable <= 4'hf;
    do begin
      @(posedge ref_clk_in);
      n++;
      if (n > 50) begin
        chk(32'(wait_w), 32'h0);
        results();
      end
    end while (wait_w !== 1'b0);
    rd = rdata_w;
    avs_req.read  <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  // Bounded wait for a channel to settle, then compare
  task automatic wait_ch(input int ch, input logic [31:0] exp);
    for (int n = 0; n < 400 && 32'(chan_w[ch]) !== exp; n++) @(posedge ref_clk_in);
    chk(32'(chan_w[ch]), exp);
    if (32'(chan_w[ch]) !== exp) results();
  endtask

  // ======================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < NUM_CH; i++) begin
      chk(32'(chan_w[i]), ce(CODE_RESET, 1'b0, PS_ACTIVE));
      rd_chk(OFS_DATA0 + 8'(4 * i), 32'h0);
    end
    chk(32'(bias_w), 32'h1);
    rd_chk(OFS_PWR, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_write();
    for (int i = 0; i < NUM_CH; i++) begin
      code_q[i] = 12'h0a5 + 12'(i * 12'h211);
      i_host.send_frame({1'b0, 3'(i), code_q[i]});
      wait_ch(i, ce(code_q[i], 1'b0, PS_ACTIVE));
      rd_chk(OFS_DATA0 + 8'(4 * i), 32'(code_q[i]));
    end
    $display("test data write done");
  endtask

  task automatic t_pdown();
    logic [3:0] ops [3] = '{OP_PD_HIZ, OP_PD_100K, OP_PD_2K5};
    logic [3:0] junk [3] = '{4'ha, 4'h5, 4'hf};
    logic [7:0] msk [3] = '{8'h05, 8'h0a, 8'hf0};
    dpc_pwr_t   trm [3] = '{PS_HIZ, PS_100K, PS_2K5};
    for (int k = 0; k < 3; k++) begin
      i_host.send_frame({ops[k], junk[k], msk[k]});
      for (int i = 0; i < NUM_CH; i++) begin
        if (msk[k][i]) wait_ch(i, ce(12'h000, 1'b1, trm[k]));
      end
      // Unselected channel untouched by the first frame
      if (k == 0) chk(32'(chan_w[1]), ce(code_q[1], 1'b0, PS_ACTIVE));
      repeat (4) @(posedge ref_clk_in);
      chk(32'(bias_w), 32'(k < 2));
    end
    // Broadcast opcode is not implemented and must leave every channel alone
    i_host.send_frame({4'hc, 12'h7ff});
    repeat (8) @(posedge ref_clk_in);
    chk(32'(chan_w[0]), ce(12'h000, 1'b1, PS_HIZ));
    for (int i = 0; i < NUM_CH; i++) begin
      rd_chk(OFS_DATA0 + 8'(4 * i), 32'(code_q[i]));
    end
    rd_chk(OFS_PWR, 32'h0000_ff99);
    rd_chk(OFS_STATUS, 32'h000c_ff00);
    rd_chk(OFS_LAST, 32'h0000_c7ff);
    $display("test power-down done");
  endtask

  task automatic t_wake();
    logic [11:0] c;
    logic [11:0] prev;
    logic        mid;
    logic        mono;
    prev = 12'h000;
    mid  = 1'b0;
    mono = 1'b1;
    code_q[1] = 12'hc35;
    i_host.send_frame({1'b0, 3'd1, code_q[1]});
    // Whole recovery must fit in 20 us, 4000 cycles at 200 MHz
    for (int n = 0; n < 4000 && chan_w[1].code !== code_q[1]; n++) begin
      @(posedge ref_clk_in);
      c = chan_w[1].code;
      if (c < prev) mono = 1'b0;
      if (c > 12'h000 && c < code_q[1]) mid = 1'b1;
      prev = c;
    end
    chk(32'(chan_w[1]), ce(code_q[1], 1'b0, PS_ACTIVE));
    if (chan_w[1].code !== code_q[1]) results();
    chk({31'h0, mid}, 32'h1);
    chk({31'h0, mono}, 32'h1);
    repeat (4) @(posedge ref_clk_in);
    chk(32'(bias_w), 32'h1);
    rd_chk(OFS_DATA0, 32'(code_q[0]));
    wait_ch(0, ce(12'h000, 1'b1, PS_HIZ));
    $display("test wake-up done");
  endtask

  task automatic t_soft();
    wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < NUM_CH; i++) begin
      wait_ch(i, ce(CODE_RESET, 1'b0, PS_ACTIVE));
    end
    rd_chk(OFS_DATA0 + 8'h04, 32'h0);
    chk(32'(bias_w), 32'h1);
    $display("test soft reset done");
  endtask

  // ======================================
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk_in);
    chk(32'(chan_w[0].code), 32'h0);
    rst_in <= 1'b0;
    t_reset();
    t_write();
    t_pdown();
    t_wake();
    t_soft();
    results();
  end
endmodule // tb
